//--- logic/lcr_device.sv
// LED device: group call, reset call recogniser and output stage
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Ignore group address while enable clear
// RULE_02: Group address accepted for read and write
// RULE_03: Only upper seven bits match; lsb zero
// RULE_04: Power-on reset loads defaults, channels off
// RULE_05: Reset address acknowledged for write only
// RULE_06: First reset byte must be A5h
// RULE_07: Second reset byte must be 5Ah
// RULE_08: No acknowledge beyond second reset byte
// RULE_09: Stop after both bytes resets everything
// RULE_10: Master treats missing acknowledge as abort
// RULE_11: Malformed sequence causes no reset
// RULE_12: Static codes map onto transistor controls
// RULE_13: PWM codes drive lower, upper complementary
// RULE_14: Polarity flip inverts all states and PWM
// RULE_15: Push-pull bit gates upper transistor
// RULE_16: Software picks polarity per driver type
// RULE_17: Two-bit code selects off, on, PWM, group
// RULE_18: Polarity flip is bit four, resets zero
// RULE_19: Push-pull select is bit two
// RULE_20: Start or stop discards partial reset progress
// RULE_21: Compare seven address bits, direction excluded
module lcr_device #(
  parameter int CH = lcr_pkg::CHANNELS
) (
  input wire logic I_SYS_CLK, // System clock
  input wire logic I_RESET_N, // Async reset, active low
  input wire logic I_CLK_EN, // Freezes state when low
  lcr_link_if.device LINK, // Serial link
  input wire logic [7:0] I_GROUP_ADDR, // New group address value
  input wire logic I_GROUP_ADDR_WE, // Group address write strobe
  input wire logic [7:0] I_FIRST_CTRL, // New first control value
  input wire logic I_FIRST_CTRL_WE, // First control write strobe
  input wire logic [7:0] I_SECOND_CTRL, // New second control value
  input wire logic I_SECOND_CTRL_WE, // Second control write strobe
  input wire logic [2*CH-1:0] I_STATE, // New channel state codes
  input wire logic I_STATE_WE, // Channel state write strobe
  input wire logic [CH-1:0] I_PWM, // Individual PWM waveforms
  input wire logic I_GROUP_PWM, // Group waveform
  output logic [7:0] O_GROUP_ADDR, // Group address readback
  output logic O_ADDRESSED, // Group address matched
  output logic O_RESET_DONE, // Reset call performed pulse
  output logic [CH-1:0] O_UPPER_ON, // Upper transistor on
  output logic [CH-1:0] O_LOWER_ON // Lower transistor on
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_BYTE, ST_SKIP} lcr_state_t;
  typedef enum {PH_ADDR, PH_B1, PH_B2, PH_DONE, PH_OTHER} lcr_phase_t;
  //////////////////////////////////////////////////////////////////////////
  // Link synchronisers and edge detection
  logic [1:0] scl_sync_reg, scl_sync_next;
  logic [1:0] sda_sync_reg, sda_sync_next;
  logic scl_d_reg, scl_d_next, sda_d_reg, sda_d_next;
  logic scl_rise, scl_fall, start_det, stop_det;
  always_comb begin
    scl_sync_next = {scl_sync_reg[0], LINK.scl};
    sda_sync_next = {sda_sync_reg[0], LINK.sda};
    scl_d_next = scl_sync_reg[1];
    sda_d_next = sda_sync_reg[1];
  end
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (I_CLK_EN) begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
    end
  end
  // Bus events from the second stage only
  assign scl_rise = scl_sync_reg[1] & ~scl_d_reg;
  assign scl_fall = ~scl_sync_reg[1] & scl_d_reg;
  assign start_det = scl_sync_reg[1] & scl_d_reg & ~sda_sync_reg[1] & sda_d_reg;
  assign stop_det = scl_sync_reg[1] & scl_d_reg & sda_sync_reg[1] & ~sda_d_reg;
  //////////////////////////////////////////////////////////////////////////
  // Serial slave state machine
  lcr_state_t st_reg, st_next;
  lcr_phase_t ph_reg, ph_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic ack_reg, ack_next;
  logic oe_n_reg, oe_n_next;
  logic hit_reg, hit_next;
  logic rst_call, done_next;
  logic [7:0] gaddr_reg, gaddr_next;
  logic [7:0] first_reg, first_next;
  logic [7:0] second_reg, second_next;
  logic [2*CH-1:0] code_reg, code_next;
  logic [7:0] rx;
  localparam logic [3:0] BIT_LAST = lcr_pkg::BIT_COUNT_ACK - 4'h1;
  always_comb begin
    st_next = st_reg;
    ph_next = ph_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    ack_next = ack_reg;
    oe_n_next = oe_n_reg;
    hit_next = hit_reg;
    rst_call = 1'b0;
    rx = {sh_reg[6:0], sda_sync_reg[1]};
    if (stop_det) begin
      rst_call = (ph_reg == PH_DONE); // [RULE_09] [RULE_11]
      st_next = ST_IDLE; // [RULE_20]
      ph_next = PH_ADDR;
      oe_n_next = 1'b1;
      hit_next = 1'b0;
    end else if (start_det) begin
      st_next = ST_ADDR; // [RULE_20]
      ph_next = PH_ADDR;
      cnt_next = '0;
      oe_n_next = 1'b1;
      hit_next = 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
        end
        ST_ADDR, ST_BYTE: begin
          if (scl_rise) begin
            sh_next = rx;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == BIT_LAST) begin
              st_next = ST_ACK;
              ack_next = 1'b0;
              if (ph_reg == PH_ADDR) begin
                if (rx[7:1] == lcr_pkg::RESET_CALL_ADDR && !rx[0]) begin
                  ack_next = 1'b1; // [RULE_05]
                  ph_next = PH_B1;
                end else if (first_reg[lcr_pkg::GROUP_ENABLE_BIT] &&
                    rx[7:1] == gaddr_reg[7:1]) begin
                  ack_next = 1'b1; // [RULE_01] [RULE_02] [RULE_21]
                  hit_next = 1'b1;
                  ph_next = PH_OTHER;
                end else begin
                  ph_next = PH_OTHER;
                end
              end else if (ph_reg == PH_B1) begin
                ack_next = (rx == lcr_pkg::RESET_BYTE_1); // [RULE_06]
                ph_next = ack_next ? PH_B2 : PH_OTHER;
              end else if (ph_reg == PH_B2) begin
                ack_next = (rx == lcr_pkg::RESET_BYTE_2); // [RULE_07]
                ph_next = ack_next ? PH_DONE : PH_OTHER;
              end else begin
                ack_next = hit_reg && ph_reg == PH_OTHER; // [RULE_02]
                ph_next = ph_reg == PH_DONE ? PH_OTHER : ph_reg; // [RULE_08]
              end
            end
          end
        end
        ST_ACK: begin
          // A refused byte goes straight to skip; its slot is left free
          if (scl_fall && oe_n_reg && ack_reg) begin
            oe_n_next = 1'b0;
          end else if (scl_fall && oe_n_reg) begin
            cnt_next = '0;
            st_next = ST_SKIP; // [RULE_10]
          end else if (scl_fall) begin
            oe_n_next = 1'b1;
            cnt_next = '0;
            st_next = ST_BYTE;
          end
        end
        ST_SKIP: begin
        end
        default: st_next = ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_reg <= ST_IDLE; // [RULE_04]
      ph_reg <= PH_ADDR;
      sh_reg <= '0;
      cnt_reg <= '0;
      ack_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      hit_reg <= 1'b0;
    end else if (I_CLK_EN) begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      ack_reg <= ack_next;
      oe_n_reg <= oe_n_next;
      hit_reg <= hit_next;
    end
  end
  assign LINK.sda_s_o = 1'b0;
  assign LINK.sda_s_oe_n = oe_n_reg;
  //////////////////////////////////////////////////////////////////////////
  // Control registers, reset by power-on or reset call
  always_comb begin
    gaddr_next = gaddr_reg;
    first_next = first_reg;
    second_next = second_reg;
    code_next = code_reg;
    done_next = 1'b0;
    if (rst_call) begin
      gaddr_next = lcr_pkg::GROUP_ADDR_RESET; // [RULE_09]
      first_next = lcr_pkg::FIRST_CTRL_RESET;
      second_next = lcr_pkg::SECOND_CTRL_RESET;
      code_next = '0;
      done_next = 1'b1;
    end else begin
      if (I_GROUP_ADDR_WE) gaddr_next = {I_GROUP_ADDR[7:1], 1'b0}; // [RULE_03]
      if (I_FIRST_CTRL_WE) first_next = I_FIRST_CTRL;
      if (I_SECOND_CTRL_WE) second_next = I_SECOND_CTRL;
      if (I_STATE_WE) code_next = I_STATE;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Output stage mapping
  function automatic logic [1:0] drive(input logic [1:0] code,
      input logic pwm, input logic grp, input logic flip, input logic pp);
    logic lvl;
    logic up;
    lvl = 1'b0;
    up = 1'b0;
    unique case (code) // [RULE_17]
      lcr_pkg::CODE_OFF: begin lvl = 1'b0; up = 1'b0; end
      lcr_pkg::CODE_ON: begin lvl = 1'b1; up = 1'b1; end
      lcr_pkg::CODE_PWM: begin lvl = pwm; up = pwm; end
      lcr_pkg::CODE_GROUP: begin lvl = pwm & grp; up = pwm; end // [RULE_13]
    endcase
    lvl = lvl ^ flip; // [RULE_14]
    up = up ^ flip;
    if (code[1]) drive = {pp & ~up, lvl}; // [RULE_13] [RULE_15]
    else drive = {pp & ~lvl, lvl}; // [RULE_12] [RULE_15]
  endfunction : drive
  logic [CH-1:0] up_next, lo_next;
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      {up_next[i], lo_next[i]} = drive(code_reg[2*i +: 2], I_PWM[i],
        I_GROUP_PWM, second_reg[lcr_pkg::POLARITY_BIT], // [RULE_18]
        second_reg[lcr_pkg::PUSH_PULL_BIT]); // [RULE_19]
    end
  end
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      gaddr_reg <= lcr_pkg::GROUP_ADDR_RESET; // [RULE_04]
      first_reg <= lcr_pkg::FIRST_CTRL_RESET;
      second_reg <= lcr_pkg::SECOND_CTRL_RESET;
      code_reg <= '0;
      O_RESET_DONE <= 1'b0;
      O_ADDRESSED <= 1'b0;
      O_GROUP_ADDR <= lcr_pkg::GROUP_ADDR_RESET;
      O_UPPER_ON <= '0;
      O_LOWER_ON <= '0;
    end else if (I_CLK_EN) begin
      gaddr_reg <= gaddr_next;
      first_reg <= first_next;
      second_reg <= second_next;
      code_reg <= code_next;
      O_RESET_DONE <= done_next;
      O_ADDRESSED <= hit_next;
      O_GROUP_ADDR <= gaddr_next;
      O_UPPER_ON <= up_next;
      O_LOWER_ON <= lo_next;
    end
  end
endmodule : lcr_device

//--- logic/lcr_pkg.sv
// Shared constants for the group call, reset call and output stage block
package lcr_pkg;
  localparam int CHANNELS = 4;
  localparam logic [6:0] RESET_CALL_ADDR = 7'h03;
  localparam logic [7:0] RESET_BYTE_1 = 8'hA5;
  localparam logic [7:0] RESET_BYTE_2 = 8'h5A;
  localparam logic [7:0] GROUP_ADDR_RESET = 8'hE0;
  localparam logic [7:0] SECOND_CTRL_RESET = 8'h05;
  localparam logic [7:0] FIRST_CTRL_RESET = 8'h11;
  localparam int GROUP_ENABLE_BIT = 0;
  localparam int POLARITY_BIT = 4;
  localparam int PUSH_PULL_BIT = 2;
  localparam logic [1:0] CODE_OFF = 2'h0;
  localparam logic [1:0] CODE_ON = 2'h1;
  localparam logic [1:0] CODE_PWM = 2'h2;
  localparam logic [1:0] CODE_GROUP = 2'h3;
  localparam logic [3:0] BIT_COUNT_ACK = 4'h8;
  localparam int LINK_DIV = 6;
endpackage : lcr_pkg

//--- logic/lcr_link_if.sv
// Two-wire serial link between master and LED device
`timescale 1ns/1ps
interface lcr_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  wire scl = scl_oe_n ? 1'b1 : scl_o;
  wire sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);
  modport master (output scl_o, output scl_oe_n, output sda_m_o,
    output sda_m_oe_n, input scl, input sda);
  modport device (output sda_s_o, output sda_s_oe_n, input scl, input sda);
endinterface : lcr_link_if

//--- logic/lcr_master.sv
// Serial master sending address and data bytes to the LED device
`timescale 1ns/1ps
module lcr_master #(
  parameter int DIV = lcr_pkg::LINK_DIV
) (
  input wire logic I_SYS_CLK, // System clock
  input wire logic I_RESET_N, // Async reset, active low
  input wire logic I_CLK_EN, // Freezes state when low
  lcr_link_if.master LINK, // Serial link
  input wire logic I_GO, // Start a transfer pulse
  input wire logic [7:0] I_ADDR, // Address byte incl. direction
  input wire logic [7:0] I_BYTE1, // First data byte
  input wire logic [7:0] I_BYTE2, // Second data byte
  input wire logic [1:0] I_NBYTES, // Data bytes to send
  output logic O_BUSY, // Transfer in progress
  output logic O_DONE, // Transfer finished pulse
  output logic O_ABORT // Missing acknowledge seen
);
  typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} lcr_mstate_t;
  lcr_mstate_t st_reg, st_next;
  logic [7:0] div_reg, div_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next;
  logic [1:0] idx_reg, idx_next;
  logic [7:0] sh_reg, sh_next;
  logic scl_reg, scl_next, sda_reg, sda_next;
  logic busy_next, done_next, abort_next, nack_reg, nack_next;
  logic [1:0] sda_sync_reg;
  logic tick;
  function automatic logic [7:0] pick(input logic [1:0] idx,
      input logic [7:0] a, input logic [7:0] b);
    pick = (idx == 2'h1) ? a : b;
  endfunction : pick
  //////////////////////////////////////////////////////////////////////////
  // Quarter-period tick and bus sequencer
  assign tick = (div_reg == 8'(DIV - 1));
  always_comb begin
    st_next = st_reg;
    div_next = tick ? 8'h00 : div_reg + 8'h01;
    ph_next = ph_reg;
    bit_next = bit_reg;
    idx_next = idx_reg;
    sh_next = sh_reg;
    scl_next = scl_reg;
    sda_next = sda_reg;
    nack_next = nack_reg;
    done_next = 1'b0;
    abort_next = 1'b0;
    if (st_reg == M_IDLE) begin
      div_next = 8'h00;
      if (I_GO) begin
        st_next = M_START;
        ph_next = 2'h0;
        sh_next = I_ADDR;
        idx_next = 2'h0;
        nack_next = 1'b0;
      end
    end else if (tick) begin
      ph_next = ph_reg + 2'h1;
      unique case (st_reg)
        M_START: begin
          if (ph_reg == 2'h1) sda_next = 1'b0;
          if (ph_reg == 2'h3) begin
            scl_next = 1'b0;
            st_next = M_BIT;
            bit_next = 4'h0;
          end
        end
        M_BIT, M_ACK: begin
          if (ph_reg == 2'h0) begin
            sda_next = (st_reg == M_ACK) ? 1'b1 : sh_reg[7];
          end
          if (ph_reg == 2'h1) scl_next = 1'b1;
          if (ph_reg == 2'h2 && st_reg == M_ACK) begin
            nack_next = sda_sync_reg[1]; // [RULE_10]
          end
          if (ph_reg == 2'h3) begin
            scl_next = 1'b0;
            if (st_reg == M_BIT) begin
              sh_next = {sh_reg[6:0], 1'b0};
              bit_next = bit_reg + 4'h1;
              if (bit_reg == lcr_pkg::BIT_COUNT_ACK - 4'h1) st_next = M_ACK;
            end else if (nack_reg || idx_reg == I_NBYTES) begin
              st_next = M_STOP; // [RULE_09]
            end else begin
              idx_next = idx_reg + 2'h1;
              sh_next = pick(idx_reg + 2'h1, I_BYTE1, I_BYTE2); // [RULE_06]
              bit_next = 4'h0;
              st_next = M_BIT; // [RULE_07]
            end
          end
        end
        M_STOP: begin
          if (ph_reg == 2'h0) sda_next = 1'b0;
          if (ph_reg == 2'h1) scl_next = 1'b1;
          if (ph_reg == 2'h2) sda_next = 1'b1;
          if (ph_reg == 2'h3) begin
            st_next = M_IDLE;
            done_next = 1'b1;
            abort_next = nack_reg;
          end
        end
        default: st_next = M_IDLE;
      endcase
    end
    busy_next = (st_next != M_IDLE);
  end
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_reg <= M_IDLE;
      div_reg <= 8'h00;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      idx_reg <= 2'h0;
      sh_reg <= 8'h00;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      nack_reg <= 1'b0;
      sda_sync_reg <= 2'h3;
      O_BUSY <= 1'b0;
      O_DONE <= 1'b0;
      O_ABORT <= 1'b0;
    end else if (I_CLK_EN) begin
      st_reg <= st_next;
      div_reg <= div_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      idx_reg <= idx_next;
      sh_reg <= sh_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      nack_reg <= nack_next;
      sda_sync_reg <= {sda_sync_reg[0], LINK.sda};
      O_BUSY <= busy_next;
      O_DONE <= done_next;
      O_ABORT <= abort_next;
    end
  end
  // Open-drain drive: enable low only while pulling low
  assign LINK.scl_o = 1'b0;
  assign LINK.scl_oe_n = scl_reg;
  assign LINK.sda_m_o = 1'b0;
  assign LINK.sda_m_oe_n = sda_reg;
endmodule : lcr_master

//--- sim/lcr_link_checker.sv
// Assertions on the serial link between master and LED device
`timescale 1ns/1ps
module lcr_link_checker (
  input wire logic I_SYS_CLK, // System clock
  input wire logic I_RESET_N, // Async reset, active low
  input wire logic scl, // Clock wire
  input wire logic sda, // Data wire
  input wire logic scl_o, // Master clock value
  input wire logic scl_oe_n, // Master clock enable
  input wire logic sda_m_o, // Master data value
  input wire logic sda_m_oe_n, // Master data enable
  input wire logic sda_s_o, // Device data value
  input wire logic sda_s_oe_n // Device data enable
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  //////////////////////////////////////////////////////////////////////
  // Steps of an acknowledge slot
  sequence s_ack_held;
    !sda_s_oe_n [*8];
  endsequence
  sequence s_ack_freed;
    ##[9:60] sda_s_oe_n;
  endsequence
  //////////////////////////////////////////////////////////////////////
  // Both ends only ever sink the wires
  property p_sink_only;
    !sda_s_o && !sda_m_o && !scl_o;
  endproperty
  a_sink_only: assert property (p_sink_only)
    else $error("link driven high");
  // Device moves data only while the clock is low
  property p_dev_scl_low;
    $changed(sda_s_oe_n) |-> !scl;
  endproperty
  a_dev_scl_low: assert property (p_dev_scl_low)
    else $error("device data moved with clock high");
  // Acknowledge holds, then ends in bounded time
  property p_ack_held;
    $fell(sda_s_oe_n) |-> s_ack_held;
  endproperty
  a_ack_held: assert property (p_ack_held)
    else $error("acknowledge too short");
  property p_ack_freed;
    $fell(sda_s_oe_n) |-> s_ack_freed;
  endproperty
  a_ack_freed: assert property (p_ack_freed)
    else $error("acknowledge never released");
  // Acknowledge starts after a clock fall
  property p_ack_after_fall;
    $fell(sda_s_oe_n) |-> !$past(scl);
  endproperty
  a_ack_after_fall: assert property (p_ack_after_fall)
    else $error("acknowledge started with clock high");
  // Master leaves data free while the device answers with the clock high
  property p_master_frees;
    !sda_s_oe_n && scl |-> sda_m_oe_n;
  endproperty
  a_master_frees: assert property (p_master_frees)
    else $error("master drove data in acknowledge");
  // Clock high phase lasts
  property p_scl_high;
    $rose(scl) |-> scl [*8];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
  // Bus stays free after a stop
  property p_bus_free;
    $rose(sda) && scl && $past(scl) |-> (scl && sda) [*4];
  endproperty
  a_bus_free: assert property (p_bus_free)
    else $error("bus not free after stop");
endmodule : lcr_link_checker

//--- sim/led_call_reset_output_stage_tb.sv
// Testbench for master and LED device joined by the serial link
`timescale 1ns/1ps
module led_call_reset_output_stage_tb;
  logic clk, rst_n, go, done, abort, busy, gpwm, addressed, rst_done;
  logic [7:0] addr, b1, b2, wd, gadr_rb;
  logic [1:0] nb;
  logic [3:0] we, pwm, up, lo;
  logic [31:0] seed = 32'h467A51B8;
  int num_errors = 0;
  int checked = 0;
  logic [2:0] exp_q[$];
  logic rst_seen = 1'b0;
  logic addr_seen = 1'b0;
  // Transistor controls with every code off and control defaults
  localparam logic FLIP0 = lcr_pkg::SECOND_CTRL_RESET[lcr_pkg::POLARITY_BIT];
  localparam logic PP0 = lcr_pkg::SECOND_CTRL_RESET[lcr_pkg::PUSH_PULL_BIT];
  localparam logic [7:0] OUT_RESET = {{4{PP0 & ~FLIP0}}, {4{FLIP0}}};
  lcr_link_if lcr_link_if_inst ();
  lcr_master lcr_master_inst (.I_SYS_CLK(clk), .I_RESET_N(rst_n),
    .I_CLK_EN(1'b1), .LINK(lcr_link_if_inst.master), .I_GO(go),
    .I_ADDR(addr), .I_BYTE1(b1), .I_BYTE2(b2), .I_NBYTES(nb),
    .O_BUSY(busy), .O_DONE(done), .O_ABORT(abort));
  lcr_device lcr_device_inst (.I_SYS_CLK(clk), .I_RESET_N(rst_n),
    .I_CLK_EN(1'b1), .LINK(lcr_link_if_inst.device), .I_GROUP_ADDR(wd),
    .I_GROUP_ADDR_WE(we[0]), .I_FIRST_CTRL(wd), .I_FIRST_CTRL_WE(we[1]),
    .I_SECOND_CTRL(wd), .I_SECOND_CTRL_WE(we[2]), .I_STATE(wd),
    .I_STATE_WE(we[3]), .I_PWM(pwm), .I_GROUP_PWM(gpwm),
    .O_GROUP_ADDR(gadr_rb), .O_ADDRESSED(addressed),
    .O_RESET_DONE(rst_done), .O_UPPER_ON(up), .O_LOWER_ON(lo));
  lcr_link_checker lcr_link_checker_inst (.I_SYS_CLK(clk),
    .I_RESET_N(rst_n), .scl(lcr_link_if_inst.scl),
    .sda(lcr_link_if_inst.sda), .scl_o(lcr_link_if_inst.scl_o),
    .scl_oe_n(lcr_link_if_inst.scl_oe_n),
    .sda_m_o(lcr_link_if_inst.sda_m_o),
    .sda_m_oe_n(lcr_link_if_inst.sda_m_oe_n),
    .sda_s_o(lcr_link_if_inst.sda_s_o),
    .sda_s_oe_n(lcr_link_if_inst.sda_s_oe_n));
  //////////////////////////////////////////////////////////////////////
  // Clock source
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Compare and count
  task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // Closing report
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // Register write strobe, one select bit per register
  task automatic wreg(input int sel, input logic [7:0] v);
    @(posedge clk);
    wd <= v;
    we <= 4'h1 << sel;
    @(posedge clk);
    we <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wreg
  // One link transfer; the abort outcome is queued for the monitor
  task automatic xfer(input logic [7:0] a, input logic [7:0] d1,
      input logic [7:0] d2, input logic [1:0] n, input logic ab);
    int k;
    // Note: group hit, reset performed, abort
    exp_q.push_back({!ab && a[7:1] != lcr_pkg::RESET_CALL_ADDR,
      a == {lcr_pkg::RESET_CALL_ADDR, 1'b0} && n == 2'h2 &&
      d1 == lcr_pkg::RESET_BYTE_1 && d2 == lcr_pkg::RESET_BYTE_2, ab});
    @(posedge clk);
    addr <= a;
    b1 <= d1;
    b2 <= d2;
    nb <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    chk("busy", {7'h00, busy}, 8'h01);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 4000);
    chk("transfer end", {7'h00, done}, 8'h01);
    chk("busy end", {7'h00, busy}, 8'h00);
    repeat (30) @(posedge clk);
    #1;
  endtask : xfer
  // Random codes and waveforms, then transistor controls compared
  task automatic out_chk(input logic flip, input logic pp);
    logic [31:0] r;
    logic [3:0] eu, el;
    logic [1:0] c;
    logic lv;
    r = rnd();
    @(posedge clk);
    wd <= r[7:0];
    we <= 4'h8;
    pwm <= r[11:8];
    gpwm <= r[12];
    @(posedge clk);
    we <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++) begin
      c = r[2*i+:2];
      lv = (c == lcr_pkg::CODE_OFF) ? 1'b0 : (c == lcr_pkg::CODE_ON) ? 1'b1
        : (c == lcr_pkg::CODE_PWM) ? r[8+i] : (r[8+i] & r[12]);
      el[i] = lv ^ flip;
      eu[i] = pp & ~((c > lcr_pkg::CODE_ON ? r[8+i] : lv) ^ flip);
    end
    chk("lower", {4'h0, lo}, {4'h0, el});
    chk("upper", {4'h0, up}, {4'h0, eu});
  endtask : out_chk
  // Monitor: each finished transfer takes the oldest note
  always @(negedge clk) begin
    logic [2:0] e;
    if (rst_done === 1'b1) rst_seen = 1'b1;
    if (addressed === 1'b1) addr_seen = 1'b1;
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spare done", 8'h01, 8'h00);
      end else begin
        e = exp_q.pop_front();
        chk("abort", {7'h00, abort}, {7'h00, e[0]});
        chk("reset", {7'h00, rst_seen}, {7'h00, e[1]});
        chk("hit", {7'h00, addr_seen}, {7'h00, e[2]});
      end
      rst_seen = 1'b0;
      addr_seen = 1'b0;
    end
  end
  // Watchdog
  initial begin
    #800000;
    num_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [7:0] ga, w;
    rst_n = 1'b0;
    go = 1'b0;
    addr = 8'h00;
    b1 = 8'h00;
    b2 = 8'h00;
    nb = 2'h0;
    wd = 8'h00;
    we = 4'h0;
    pwm = 4'h0;
    gpwm = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("group addr", gadr_rb, lcr_pkg::GROUP_ADDR_RESET);
    chk("outputs", {up, lo}, OUT_RESET);
    $display("Test reset done");
    r = rnd();
    ga = {1'b1, r[6:2], 2'h3};
    w = {r[31:25], 1'b1};
    wreg(0, ga);
    chk("group addr", gadr_rb, {ga[7:1], 1'b0});
    xfer({ga[7:1], 1'b0}, r[15:8], r[23:16], 2'h1, 1'b0);
    xfer({ga[7:1], 1'b1}, 8'h00, 8'h00, 2'h0, 1'b0);
    xfer({ga[7:1] ^ 7'h04, 1'b0}, 8'h00, 8'h00, 2'h0, 1'b1);
    wreg(1, lcr_pkg::FIRST_CTRL_RESET & 8'hFE);
    xfer({ga[7:1], 1'b0}, 8'h00, 8'h00, 2'h0, 1'b1);
    wreg(1, lcr_pkg::FIRST_CTRL_RESET);
    $display("Test group call done");
    xfer(8'h07, 8'hA5, 8'h5A, 2'h2, 1'b1);
    xfer(8'h06, 8'hA5 ^ w, 8'h5A, 2'h2, 1'b1);
    xfer(8'h06, 8'hA5, 8'h5A ^ w, 2'h2, 1'b1);
    xfer(8'h06, 8'hA5, 8'h5A, 2'h1, 1'b0);
    chk("no reset", gadr_rb, {ga[7:1], 1'b0});
    xfer(8'h06, 8'hA5, 8'h5A, 2'h3, 1'b1);
    $display("Test malformed reset call done");
    for (int i = 0; i < 4; i++) begin
      wreg(2, {3'h0, i[1], 1'b0, i[0], 2'h1});
      repeat (4) out_chk(i[1], i[0]);
    end
    $display("Test output stage done");
    wreg(0, ga);
    wreg(3, 8'h55);
    xfer(8'h06, 8'hA5, 8'h5A, 2'h2, 1'b0);
    chk("group addr", gadr_rb, lcr_pkg::GROUP_ADDR_RESET);
    chk("outputs", {up, lo}, OUT_RESET);
    wreg(3, 8'h55);
    chk("outputs", {up, lo}, 8'h0F);
    xfer(lcr_pkg::GROUP_ADDR_RESET, 8'h00, 8'h00, 2'h1, 1'b0);
    $display("Test reset call done");
    print_verdict();
  end
endmodule : led_call_reset_output_stage_tb
